/* File: logic/pwr_regs_pkg.sv */
/*
 * pwr_regs_pkg: offsets, field positions, reset values and carrier structs for the power-down
 * and output-buffer register bank.
 * Assumes a register write/read port already decoded from the serial control port.
 */
package pwr_regs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int OB_W   = 24;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_POWER_DOWN_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_OB_DISABLE_LOW     = 8'h0a;
	localparam logic [ADDR_W-1:0] OFF_OB_DISABLE_MID     = 8'h0b;
	localparam logic [ADDR_W-1:0] OFF_OB_DISABLE_HIGH    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_GLOBAL_MASK        = 8'h0d;

	// power control field positions
	localparam int BIT_SAMPLE_CLOCK_BUFFER_OFF = 5;
	localparam int BIT_REFERENCE_AMP_OFF       = 4;
	localparam int BIT_CHANNEL_A_OFF           = 2;
	localparam int BIT_GLOBAL_POWER_OFF        = 0;
	// global mask field positions
	localparam int BIT_KEEP_CLOCK_BUFFER_ON    = 3;
	localparam int BIT_KEEP_REFERENCE_AMP_ON   = 2;

	// reset values; bit 1 of the power control register resets to one
	localparam logic [DATA_W-1:0] RST_POWER_DOWN_CONTROL = 8'h02;
	localparam logic [DATA_W-1:0] RST_OB_DISABLE         = 8'h00;
	localparam logic [DATA_W-1:0] RST_GLOBAL_MASK        = 8'h00;
	localparam logic [DATA_W-1:0] READ_UNMAPPED          = 8'h00;

	// register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

	// block power-down controls
	typedef struct packed {
		logic sample_clock_buffer_off;
		logic reference_amp_off;
		logic channel_a_off;
	} block_off_s;

endpackage : pwr_regs_pkg

/* File: logic/byte_reg.sv */
/*
 * byte_reg: one byte-wide read/write configuration register with its own address match.
 * Assumes the request struct is synchronous to the clock.
 */
`timescale 1ns/1ps
module byte_reg #(
	parameter logic [pwr_regs_pkg::ADDR_W-1:0] ADDR      = 8'h00,
	parameter logic [pwr_regs_pkg::DATA_W-1:0] RST_VALUE = 8'h00
) (
	// clock and reset
	input  wire logic                            clk_in,
	input  wire logic                            rst_in,
	// register port
	input  wire pwr_regs_pkg::reg_req_s          req_in,
	output logic [pwr_regs_pkg::DATA_W-1:0]      value_out
);
	logic [pwr_regs_pkg::DATA_W-1:0] value_reg;
	logic [pwr_regs_pkg::DATA_W-1:0] value_next;

	// write takes the whole byte when the address matches
	always_comb begin
		value_next = value_reg;
		if (req_in.wr && req_in.addr == ADDR) begin
			value_next = req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			value_reg <= RST_VALUE;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value_out = value_reg;

endmodule : byte_reg

/* File: logic/power_down_and_output_buffer_regs.sv */
/*
 * power_down_and_output_buffer_regs: power control, global power-down mask and the 24-bit
 * output-buffer disable field, with the resulting block power-down outputs.
 * Assumes writes and reads arrive already decoded from the serial control port, one per cycle.
 */
`timescale 1ns/1ps
// Overview of operation
// - Power control bit 5 set to one turns off the sampling clock buffer, resetting to zero.
// - Power control bit 4 set to one turns off the reference gain amplifier, resetting to zero.
// - Power control bit 2 set to one powers down converter channel A, resetting to zero.
// - Power control bit 0 set to one invokes global power-down, qualified by the mask at 0x0d for all blocks but channel A.
// - Each set bit of the 24-bit output-buffer field powers down its buffer, all resetting to 0.
// - Mask bit 3 set keeps the clock buffer on in global power-down, clear lets it turn off.
module power_down_and_output_buffer_regs #(
	parameter int OB_W = pwr_regs_pkg::OB_W
) (
	// clock and reset
	input  wire logic                            CLOCK_IN,
	input  wire logic                            RST_IN,
	// register port
	input  wire pwr_regs_pkg::reg_req_s          REQ_IN,
	output logic [pwr_regs_pkg::DATA_W-1:0]      RDATA_OUT,
	output logic                                 RVALID_OUT,
	// power-down controls
	output pwr_regs_pkg::block_off_s             BLOCK_OFF_OUT,
	output logic [OB_W-1:0]                      OUTPUT_BUFFER_DISABLE_FIELD_OUT
);
	localparam int NREG = 5;
	localparam logic [pwr_regs_pkg::ADDR_W-1:0] ADDRS [NREG] = '{
		pwr_regs_pkg::OFF_POWER_DOWN_CONTROL, pwr_regs_pkg::OFF_OB_DISABLE_LOW,
		pwr_regs_pkg::OFF_OB_DISABLE_MID, pwr_regs_pkg::OFF_OB_DISABLE_HIGH,
		pwr_regs_pkg::OFF_GLOBAL_MASK};
	localparam logic [pwr_regs_pkg::DATA_W-1:0] RSTS [NREG] = '{
		pwr_regs_pkg::RST_POWER_DOWN_CONTROL, pwr_regs_pkg::RST_OB_DISABLE,
		pwr_regs_pkg::RST_OB_DISABLE, pwr_regs_pkg::RST_OB_DISABLE,
		pwr_regs_pkg::RST_GLOBAL_MASK};

	logic [pwr_regs_pkg::DATA_W-1:0] regs [NREG];

	// one storage byte per register; reserved bits are stored as written so software reads back
	// exactly what it wrote, no hardware meaning is attached to them
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		byte_reg #(
			.ADDR      (ADDRS[i]),
			.RST_VALUE (RSTS[i])
		) u_reg (
			.clk_in    (CLOCK_IN),
			.rst_in    (RST_IN),
			.req_in    (REQ_IN),
			.value_out (regs[i])
		);
	end

	logic [pwr_regs_pkg::DATA_W-1:0] pdc;
	logic [pwr_regs_pkg::DATA_W-1:0] mask;
	assign pdc  = regs[0];
	assign mask = regs[4];

	logic [pwr_regs_pkg::DATA_W-1:0] rdata_reg;
	logic [pwr_regs_pkg::DATA_W-1:0] rdata_next;
	logic                            rvalid_reg;
	logic                            rvalid_next;
	pwr_regs_pkg::block_off_s        off_reg;
	pwr_regs_pkg::block_off_s        off_next;
	logic [OB_W-1:0]                 ob_reg;
	logic [OB_W-1:0]                 ob_next;
	logic                            global_on;

	// read mux; unmapped offsets read zero so a probe of the rest of the map is harmless
	always_comb begin
		rdata_next  = pwr_regs_pkg::READ_UNMAPPED;
		rvalid_next = REQ_IN.rd;
		if (REQ_IN.rd) begin
			for (int k = 0; k < NREG; k++) begin
				if (REQ_IN.addr == ADDRS[k]) begin
					rdata_next = regs[k];
				end
			end
		end
	end

	// power-down decode; one cycle behind the stored bits so every output leaves a flip-flop
	always_comb begin
		global_on = pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF];
		off_next.sample_clock_buffer_off = pdc[pwr_regs_pkg::BIT_SAMPLE_CLOCK_BUFFER_OFF]
			| (global_on & ~mask[pwr_regs_pkg::BIT_KEEP_CLOCK_BUFFER_ON]);
		off_next.reference_amp_off = pdc[pwr_regs_pkg::BIT_REFERENCE_AMP_OFF]
			| (global_on & ~mask[pwr_regs_pkg::BIT_KEEP_REFERENCE_AMP_ON]);
		off_next.channel_a_off = pdc[pwr_regs_pkg::BIT_CHANNEL_A_OFF] | global_on;
		ob_next = OB_W'({regs[3], regs[2], regs[1]});
	end

	// registered outputs; reset clears every control so all blocks come up powered
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rdata_reg  <= pwr_regs_pkg::READ_UNMAPPED;
			rvalid_reg <= 1'b0;
			off_reg    <= '0;
			ob_reg     <= '0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
			off_reg    <= off_next;
			ob_reg     <= ob_next;
		end
	end

	assign RDATA_OUT                       = rdata_reg;
	assign RVALID_OUT                      = rvalid_reg;
	assign BLOCK_OFF_OUT                   = off_reg;
	assign OUTPUT_BUFFER_DISABLE_FIELD_OUT = ob_reg;

	// a write to the control register shows on the clock buffer output two edges later
	sequence s_pdc_write;
		REQ_IN.wr && REQ_IN.addr == pwr_regs_pkg::OFF_POWER_DOWN_CONTROL;
	endsequence

	a_clock_buf_off: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write ##0 REQ_IN.wdata[pwr_regs_pkg::BIT_SAMPLE_CLOCK_BUFFER_OFF] |-> ##2
		BLOCK_OFF_OUT.sample_clock_buffer_off)
		else $error("clock buffer not off after write");
	a_ref_amp_off: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write ##0 REQ_IN.wdata[pwr_regs_pkg::BIT_REFERENCE_AMP_OFF] |-> ##2
		BLOCK_OFF_OUT.reference_amp_off)
		else $error("reference amp not off after write");
	a_chan_a_follow: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		BLOCK_OFF_OUT.channel_a_off == $past(pdc[pwr_regs_pkg::BIT_CHANNEL_A_OFF]
		| pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF]))
		else $error("channel a state wrong");
	a_global_chan_off: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write ##0 REQ_IN.wdata[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] |-> ##2
		BLOCK_OFF_OUT.channel_a_off)
		else $error("global power-down did not stop channel a");
	a_bit1_reset_one: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$rose(RVALID_OUT) && $past(REQ_IN.addr) == pwr_regs_pkg::OFF_POWER_DOWN_CONTROL
		&& $past(pdc) == pwr_regs_pkg::RST_POWER_DOWN_CONTROL |-> RDATA_OUT[1])
		else $error("reserved bit 1 not read as one");
	a_ob_field_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REQ_IN.wr && REQ_IN.addr == pwr_regs_pkg::OFF_OB_DISABLE_MID |-> ##2
		OUTPUT_BUFFER_DISABLE_FIELD_OUT[15:8] == $past(REQ_IN.wdata, 2))
		else $error("output buffer field middle byte wrong");
	a_mask_keeps_clk: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] && !pdc[pwr_regs_pkg::BIT_SAMPLE_CLOCK_BUFFER_OFF]
		&& mask[pwr_regs_pkg::BIT_KEEP_CLOCK_BUFFER_ON] |=>
		!BLOCK_OFF_OUT.sample_clock_buffer_off)
		else $error("masked clock buffer was turned off");
	a_unmask_clk_off: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] && !mask[pwr_regs_pkg::BIT_KEEP_CLOCK_BUFFER_ON]
		|=> BLOCK_OFF_OUT.sample_clock_buffer_off)
		else $error("unmasked clock buffer stayed on");
	a_read_one_cycle: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REQ_IN.rd && REQ_IN.addr == pwr_regs_pkg::OFF_GLOBAL_MASK |=>
		RVALID_OUT && RDATA_OUT == $past(mask))
		else $error("mask read back wrong");

	// clearing a direct bit while global power-down is off must bring that block back up
	sequence s_pdc_write_local;
		s_pdc_write ##0 !REQ_IN.wdata[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF];
	endsequence

	a_clock_back_on: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write_local ##0 !REQ_IN.wdata[pwr_regs_pkg::BIT_SAMPLE_CLOCK_BUFFER_OFF] |-> ##2
		!BLOCK_OFF_OUT.sample_clock_buffer_off)
		else $error("clock buffer stayed off after clear");
	a_ref_back_on: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write_local ##0 !REQ_IN.wdata[pwr_regs_pkg::BIT_REFERENCE_AMP_OFF] |-> ##2
		!BLOCK_OFF_OUT.reference_amp_off)
		else $error("reference amp stayed off after clear");
	a_chan_back_on: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_pdc_write_local ##0 !REQ_IN.wdata[pwr_regs_pkg::BIT_CHANNEL_A_OFF] |-> ##2
		!BLOCK_OFF_OUT.channel_a_off)
		else $error("channel a stayed off after clear");

	// global power-down always stops channel a; the amplifier follows its own mask bit, so a
	// board that needs the reference during standby can keep it
	a_global_holds_chan: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] |=> BLOCK_OFF_OUT.channel_a_off)
		else $error("channel a on during global power-down");
	a_global_ref_off: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] && !mask[pwr_regs_pkg::BIT_KEEP_REFERENCE_AMP_ON]
		|=> BLOCK_OFF_OUT.reference_amp_off)
		else $error("unmasked reference amp stayed on");
	a_mask_keeps_ref: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		pdc[pwr_regs_pkg::BIT_GLOBAL_POWER_OFF] && !pdc[pwr_regs_pkg::BIT_REFERENCE_AMP_OFF]
		&& mask[pwr_regs_pkg::BIT_KEEP_REFERENCE_AMP_ON] |=> !BLOCK_OFF_OUT.reference_amp_off)
		else $error("masked reference amp was turned off");

	// the outer field bytes land two edges after their writes, like the middle one
	a_ob_low_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REQ_IN.wr && REQ_IN.addr == pwr_regs_pkg::OFF_OB_DISABLE_LOW |-> ##2
		OUTPUT_BUFFER_DISABLE_FIELD_OUT[pwr_regs_pkg::DATA_W-1:0] == $past(REQ_IN.wdata, 2))
		else $error("output buffer field low byte wrong");
	a_ob_high_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REQ_IN.wr && REQ_IN.addr == pwr_regs_pkg::OFF_OB_DISABLE_HIGH |-> ##2
		OUTPUT_BUFFER_DISABLE_FIELD_OUT[OB_W-1 -: pwr_regs_pkg::DATA_W] == $past(REQ_IN.wdata, 2))
		else $error("output buffer field high byte wrong");
	a_ob_field_hold: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!REQ_IN.wr ##1 !REQ_IN.wr |=> $stable(OUTPUT_BUFFER_DISABLE_FIELD_OUT))
		else $error("output buffer field changed without a write");

	// reset must leave every block powered and the read port quiet; this checks only a reset seen at a clock edge,
	// one edge later, not the clearing between edges, although the outputs clear without waiting for the clock
	a_reset_outputs: assert property (@(posedge CLOCK_IN) RST_IN |=>
		BLOCK_OFF_OUT == '0 && OUTPUT_BUFFER_DISABLE_FIELD_OUT == '0 && !RVALID_OUT)
		else $error("outputs not cleared by reset");

	// reserved control bits come back exactly as written, so software can verify its writes
	a_ctrl_read_back: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REQ_IN.rd && REQ_IN.addr == pwr_regs_pkg::OFF_POWER_DOWN_CONTROL |=>
		RVALID_OUT && RDATA_OUT == $past(pdc))
		else $error("control register read back wrong");

	// any offset outside this bank answers zero with a valid strobe
	sequence s_unmapped_read;
		REQ_IN.rd && REQ_IN.addr != pwr_regs_pkg::OFF_POWER_DOWN_CONTROL
		&& REQ_IN.addr != pwr_regs_pkg::OFF_OB_DISABLE_LOW
		&& REQ_IN.addr != pwr_regs_pkg::OFF_OB_DISABLE_MID
		&& REQ_IN.addr != pwr_regs_pkg::OFF_OB_DISABLE_HIGH
		&& REQ_IN.addr != pwr_regs_pkg::OFF_GLOBAL_MASK;
	endsequence

	a_unmapped_read_zero: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_unmapped_read |=> RVALID_OUT && RDATA_OUT == pwr_regs_pkg::READ_UNMAPPED)
		else $error("unmapped read not zero");

	// the read strobe is high only in the cycle after a read request and the data lines rest at zero around it
	a_rvalid_no_read: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!REQ_IN.rd |=> !RVALID_OUT)
		else $error("read valid without a read");
	a_rdata_idle_zero: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!RVALID_OUT |-> RDATA_OUT == pwr_regs_pkg::READ_UNMAPPED)
		else $error("read data not zero while idle");

endmodule : power_down_and_output_buffer_regs

/* File: bench/power_down_and_output_buffer_regs_tb_top.sv */
/*
 * power_down_and_output_buffer_regs_tb_top: self-checking bench for the power-down register bank.
 * Assumes the decoded parallel register port, with read data one edge after the request.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("Error at %0t: got %h exp %h", $time, (got), (exp)); end end
module power_down_and_output_buffer_regs_tb_top;
	logic                     clk;
	logic                     rst;
	pwr_regs_pkg::reg_req_s   req;
	logic [7:0]               rdata;
	logic                     rvalid;
	pwr_regs_pkg::block_off_s boff;
	logic [23:0]              field;
	int                       n_mismatch;
	int                       cmp_count;
	// global power-down cases: mask, control, expected block controls
	logic [7:0]               g_mask[6] = '{8'h00, 8'h08, 8'h04, 8'h0c, 8'h0c, 8'h0c};
	logic [7:0]               g_ctrl[6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h23, 8'h02};
	logic [2:0]               g_exp[6]  = '{3'b111, 3'b011, 3'b101, 3'b001, 3'b101, 3'b000};
	// single control bits with the mask clear
	logic [7:0]               s_ctrl[4] = '{8'h22, 8'h12, 8'h06, 8'h02};
	logic [2:0]               s_exp[4]  = '{3'b100, 3'b010, 3'b001, 3'b000};

	power_down_and_output_buffer_regs dut (
		.CLOCK_IN                        (clk),
		.RST_IN                          (rst),
		.REQ_IN                          (req),
		.RDATA_OUT                       (rdata),
		.RVALID_OUT                      (rvalid),
		.BLOCK_OFF_OUT                   (boff),
		.OUTPUT_BUFFER_DISABLE_FIELD_OUT (field)
	);

	// 250 MHz clock
	always #2 clk = ~clk;

	// closing report, reached from the main sequence or a timed-out wait
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results

	// leaves wr high so writes can go back to back; close with idle or a read
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1;
	endtask : wr_reg

	task idle;
		req = '0;
		@(posedge clk);
		#1;
	endtask : idle

	// one read pulse, then a quiet cycle so the next request never lands in the same step
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		int i;
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1;
		req = '0;
		i = 0;
		while (rvalid !== 1'b1 && i < 4) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (rvalid !== 1'b1) begin
			n_mismatch++;
			results();
		end
		`CHK(rdata, e)
		@(posedge clk);
		#1;
	endtask : rd_chk

	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		`CHK(boff, 3'b000)
		`CHK(field, 24'h000000)
		rd_chk(8'h08, 8'h02);
		for (int i = 8'h0a; i <= 8'h0d; i++) rd_chk(8'(i), 8'h00);
		rd_chk(8'h09, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h08, s_ctrl[i]);
			idle();
			`CHK(boff, s_exp[i])
			rd_chk(8'h08, s_ctrl[i]);
		end
		for (int i = 0; i < 6; i++) begin
			wr_reg(8'h0d, g_mask[i]);
			wr_reg(8'h08, g_ctrl[i]);
			idle();
			`CHK(boff, g_exp[i])
		end
		// back-to-back writes across the three field bytes
		wr_reg(8'h0a, 8'h60);
		wr_reg(8'h0b, 8'h1e);
		wr_reg(8'h0c, 8'h0c);
		idle();
		`CHK(field, 24'h0c1e60)
		rd_chk(8'h0b, 8'h1e);
		wr_reg(8'h0a, 8'h01);
		wr_reg(8'h0c, 8'h80);
		wr_reg(8'h09, 8'hff);
		idle();
		`CHK(field, 24'h801e01)
		rd_chk(8'h09, 8'h00);
		// reset in mid-run must clear live controls
		wr_reg(8'h08, 8'h27);
		idle();
		`CHK(boff, 3'b101)
		rst = 1'b1;
		@(posedge clk);
		#1 rst = 1'b0;
		`CHK(boff, 3'b000)
		`CHK(field, 24'h000000)
		rd_chk(8'h08, 8'h02);
		rd_chk(8'h0d, 8'h00);
		results();
	end
endmodule : power_down_and_output_buffer_regs_tb_top
